/* File: rtl/cscr_pkg.sv */
`default_nettype none
package cscr_pkg;
	localparam int          FRAME_BITS   = 32;
	localparam int          ADDR_LSB     = 16;
	localparam logic [11:0] HEADER_CODE  = 12'h001;
	localparam logic [3:0]  ADDR_CONFIG  = 4'h1;
	localparam logic [3:0]  ADDR_I_OFS   = 4'h2;
	localparam logic [3:0]  ADDR_I_FS    = 4'h3;
	localparam logic [3:0]  ADDR_Q_OFS   = 4'ha;
	localparam logic [3:0]  ADDR_Q_FS    = 4'hb;
	localparam logic [3:0]  ADDR_DES_EN  = 4'hd;
	localparam logic [3:0]  ADDR_DES_CRS = 4'he;
	localparam logic [3:0]  ADDR_DES_FIN = 4'hf;
	localparam logic [15:0] RST_CONFIG   = 16'hb2ff;
	localparam logic [15:0] RST_OFS      = 16'h007f;
	localparam logic [15:0] RST_FS       = 16'h807f;
	localparam logic [15:0] RST_DES_EN   = 16'h3fff;
	localparam logic [15:0] RST_DES_CRS  = 16'h07ff;
	localparam logic [15:0] RST_DES_FIN  = 16'h007f;
	localparam int          CFG_DUTY     = 12;
	localparam int          CFG_PHASE    = 11;
	localparam int          CFG_SDR      = 10;
	localparam int          CFG_SWING    = 9;
	localparam int          CFG_EDGE     = 8;
endpackage
`default_nettype wire

/* File: rtl/cscr_sync.sv */
`default_nettype none
module cscr_sync #(
	parameter int WIDTH = 3
) (
	input  wire logic             i_clk,
	input  wire logic             i_rst,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] meta_reg;

	// Two flip-flops per pin; the first is read only by the second.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			meta_reg <= '0;
			o_sync   <= '0;
		end else begin
			meta_reg <= i_async;
			o_sync   <= meta_reg;
		end
	end
endmodule // cscr_sync
`default_nettype wire

/* File: rtl/cscr_regs.sv */
`default_nettype none
module cscr_regs (
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic        i_serial_clk,
	input  wire logic        i_serial_select_n,
	input  wire logic        i_serial_input_line,
	input  wire logic        i_extended_mode,
	output logic             o_clock_duty_stabilizer,
	output logic             o_ddr_strobe_phase,
	output logic             o_double_rate_disable,
	output logic             o_output_swing_select,
	output logic             o_output_edge_select,
	output logic [8:0]       o_i_offset,
	output logic [8:0]       o_q_offset,
	output logic [8:0]       o_i_fullscale,
	output logic [8:0]       o_q_fullscale,
	output logic [15:0]      o_des_enable,
	output logic [15:0]      o_des_coarse,
	output logic [15:0]      o_des_fine
);
	logic [2:0]  pins_sync;
	logic        sclk_prev_reg;
	logic [30:0] shift_reg;
	logic [4:0]  count_reg;
	logic [15:0] config_reg;
	logic [15:0] i_ofs_reg;
	logic [15:0] i_fs_reg;
	logic [15:0] q_ofs_reg;
	logic [15:0] q_fs_reg;
	logic [15:0] des_en_reg;
	logic [15:0] des_crs_reg;
	logic [15:0] des_fin_reg;
	logic        ext_reg;

	cscr_sync #(
		.WIDTH (3)
	) u_sync (
		.i_clk   (i_clk),
		.i_rst   (i_rst),
		.i_async ({i_serial_clk, i_serial_select_n, i_serial_input_line}),
		.o_sync  (pins_sync)
	);

	// Top bit of the address field within a frame.
	localparam int ADDR_HI = cscr_pkg::ADDR_LSB + 3;

	// Rising serial clock while selected shifts one bit in.
	wire        sclk_s   = pins_sync[2];
	wire        sel_n_s  = pins_sync[1];
	wire        serial_input_line_s  = pins_sync[0];
	wire        bit_take = sclk_s & ~sclk_prev_reg & ~sel_n_s;
	wire [31:0] frame    = {shift_reg, serial_input_line_s};
	wire        last_bit = bit_take && (count_reg == 5'h1f);
	wire [3:0]  waddr    = frame[ADDR_HI:cscr_pkg::ADDR_LSB];
	wire [15:0] wdata    = frame[15:0];

	// Register write strobe for a given address.
	function automatic logic wr_hit(input logic [3:0] a, input logic [3:0] s);
		wr_hit = (a == s);
	endfunction

	wire we_cfg  = last_bit && wr_hit(waddr, cscr_pkg::ADDR_CONFIG);
	wire we_iofs = last_bit && wr_hit(waddr, cscr_pkg::ADDR_I_OFS);
	wire we_ifs  = last_bit && wr_hit(waddr, cscr_pkg::ADDR_I_FS);
	wire we_qofs = last_bit && wr_hit(waddr, cscr_pkg::ADDR_Q_OFS);
	wire we_qfs  = last_bit && wr_hit(waddr, cscr_pkg::ADDR_Q_FS);
	wire we_den  = last_bit && wr_hit(waddr, cscr_pkg::ADDR_DES_EN);
	wire we_dcr  = last_bit && wr_hit(waddr, cscr_pkg::ADDR_DES_CRS);
	wire we_dfi  = last_bit && wr_hit(waddr, cscr_pkg::ADDR_DES_FIN);
	wire any_we  = we_cfg | we_iofs | we_ifs | we_qofs | we_qfs |
		we_den | we_dcr | we_dfi;

	// Shifter and bit counter; deselect restarts the frame count.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			sclk_prev_reg <= 1'b0;
			shift_reg     <= '0;
			count_reg     <= '0;
		end else begin
			sclk_prev_reg <= sclk_s;
			if (sel_n_s) begin
				count_reg <= '0;
			end else if (bit_take) begin
				shift_reg <= frame[30:0];
				count_reg <= count_reg + 5'h01;
			end
		end
	end

	// Register bank; unmatched addresses write nothing.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			config_reg  <= cscr_pkg::RST_CONFIG;
			i_ofs_reg   <= cscr_pkg::RST_OFS;
			i_fs_reg    <= cscr_pkg::RST_FS;
			q_ofs_reg   <= cscr_pkg::RST_OFS;
			q_fs_reg    <= cscr_pkg::RST_FS;
			des_en_reg  <= cscr_pkg::RST_DES_EN;
			des_crs_reg <= cscr_pkg::RST_DES_CRS;
			des_fin_reg <= cscr_pkg::RST_DES_FIN;
		end else begin
			if (we_cfg) config_reg <= wdata;
			if (we_iofs) i_ofs_reg <= wdata;
			if (we_ifs) i_fs_reg <= wdata;
			if (we_qofs) q_ofs_reg <= wdata;
			if (we_qfs) q_fs_reg <= wdata;
			if (we_den) des_en_reg <= wdata;
			if (we_dcr) des_crs_reg <= wdata;
			if (we_dfi) des_fin_reg <= wdata;
		end
	end

	// Effective settings: power-on values in normal mode, register else.
	wire [15:0] cfg_eff = ext_reg ? config_reg : cscr_pkg::RST_CONFIG;
	wire [15:0] iof_eff = ext_reg ? i_ofs_reg : cscr_pkg::RST_OFS;
	wire [15:0] qof_eff = ext_reg ? q_ofs_reg : cscr_pkg::RST_OFS;
	wire [15:0] ifs_eff = ext_reg ? i_fs_reg : cscr_pkg::RST_FS;
	wire [15:0] qfs_eff = ext_reg ? q_fs_reg : cscr_pkg::RST_FS;
	wire [15:0] den_eff = ext_reg ? des_en_reg : cscr_pkg::RST_DES_EN;
	wire [15:0] dcr_eff = ext_reg ? des_crs_reg : cscr_pkg::RST_DES_CRS;
	wire [15:0] dfi_eff = ext_reg ? des_fin_reg : cscr_pkg::RST_DES_FIN;

	// Registered outputs; full-scale follows directly with no calibration.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ext_reg                 <= 1'b0;
			o_clock_duty_stabilizer <= 1'b1;
			o_ddr_strobe_phase      <= 1'b0;
			o_double_rate_disable   <= 1'b0;
			o_output_swing_select   <= 1'b1;
			o_output_edge_select    <= 1'b0;
			o_i_offset              <= '0;
			o_q_offset              <= '0;
			o_i_fullscale           <= cscr_pkg::RST_FS[15:7];
			o_q_fullscale           <= cscr_pkg::RST_FS[15:7];
			o_des_enable            <= cscr_pkg::RST_DES_EN;
			o_des_coarse            <= cscr_pkg::RST_DES_CRS;
			o_des_fine              <= cscr_pkg::RST_DES_FIN;
		end else begin
			ext_reg                 <= i_extended_mode;
			o_clock_duty_stabilizer <= cfg_eff[cscr_pkg::CFG_DUTY];
			o_ddr_strobe_phase      <= cfg_eff[cscr_pkg::CFG_PHASE];
			o_double_rate_disable   <= cfg_eff[cscr_pkg::CFG_SDR];
			o_output_swing_select   <= cfg_eff[cscr_pkg::CFG_SWING];
			o_output_edge_select    <= cfg_eff[cscr_pkg::CFG_EDGE];
			o_i_offset              <= {iof_eff[7], iof_eff[15:8]};
			o_q_offset              <= {qof_eff[7], qof_eff[15:8]};
			o_i_fullscale           <= ifs_eff[15:7];
			o_q_fullscale           <= qfs_eff[15:7];
			o_des_enable            <= den_eff;
			o_des_coarse            <= dcr_eff;
			o_des_fine              <= dfi_eff;
		end
	end

	// A write lands only on the last bit of a full frame.
	write_on_last_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		we_cfg |=> config_reg == $past(wdata))
		else $error("Config write lost.");
	hold_no_frame_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		!last_bit |=> $stable(config_reg) && $stable(i_fs_reg))
		else $error("Register changed without a full frame.");
	reserved_quiet_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		(last_bit && waddr == 4'h0) |=> $stable(config_reg))
		else $error("Reserved write changed config.");
	reserved_all_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		(last_bit && !any_we) |=> $stable({config_reg, i_ofs_reg,
			i_fs_reg, q_ofs_reg, q_fs_reg, des_en_reg, des_crs_reg,
			des_fin_reg}))
		else $error("Reserved write changed a register.");
	count_wraps_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		(last_bit && !sel_n_s) |=> count_reg == 5'h00)
		else $error("Frame counter did not restart.");
	deselect_clear_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		sel_n_s |=> count_reg == 5'h00)
		else $error("Deselect kept a partial frame.");
	shift_in_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		bit_take |=> shift_reg[0] == $past(serial_input_line_s))
		else $error("Serial bit not shifted in.");

	// Outputs follow the stored words in extended mode only.
	normal_mode_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		!ext_reg |=> o_clock_duty_stabilizer && o_i_offset == 9'h000)
		else $error("Register leaked in normal mode.");
	duty_follow_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		ext_reg |=> o_clock_duty_stabilizer ==
			$past(config_reg[cscr_pkg::CFG_DUTY]))
		else $error("Duty stabilizer mismatch.");
	phase_follow_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		ext_reg |=> o_ddr_strobe_phase ==
			$past(config_reg[cscr_pkg::CFG_PHASE]))
		else $error("Clock phase mismatch.");
	swing_follow_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		ext_reg |=> o_output_swing_select == $past(config_reg[9]))
		else $error("Swing select mismatch.");
	sdr_follow_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		ext_reg |=> o_double_rate_disable == $past(config_reg[10]))
		else $error("Rate select mismatch.");
	edge_follow_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		ext_reg |=> o_output_edge_select ==
			$past(config_reg[cscr_pkg::CFG_EDGE]))
		else $error("Output edge mismatch.");
	offset_map_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		ext_reg |=> o_i_offset == $past({i_ofs_reg[7], i_ofs_reg[15:8]}))
		else $error("I offset mismatch.");
	q_offset_map_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		ext_reg |=> o_q_offset == $past({q_ofs_reg[7], q_ofs_reg[15:8]}))
		else $error("Q offset mismatch.");
	fullscale_map_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		ext_reg |=> o_i_fullscale == $past(i_fs_reg[15:7]))
		else $error("Full-scale mismatch.");
	fs_direct_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		(we_ifs && ext_reg) ##1 ext_reg |=>
			o_i_fullscale == $past(wdata[15:7], 2))
		else $error("Full-scale write did not apply.");
	no_take_idle_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		sel_n_s |-> !bit_take)
		else $error("Bit taken while deselected.");
endmodule // cscr_regs
`default_nettype wire

/* File: verif/cscr_host.sv */
`default_nettype none
// Host side of the three-wire serial port, paced by the system clock.
module cscr_host (
	input  wire logic i_clk,
	output logic      o_serial_clk,
	output logic      o_serial_select_n,
	output logic      o_serial_input_line
);
	timeunit 1ns;
	timeprecision 1ps;
	// The serial clock is parked low outside frames.
	initial begin
		o_serial_clk = 1'b0;
		o_serial_select_n = 1'b1;
		o_serial_input_line = 1'b0;
	end
	// Shifts the top nbits of a frame MSB first, 64 ns per bit.
	task automatic send(input logic [31:0] frame, input int nbits,
		input bit rel);
		o_serial_select_n <= 1'b0;
		// Data moves with the falling clock, four cycles ahead of the rise.
		for (int i = 31; i > 31 - nbits; i--) begin
			o_serial_input_line <= frame[i];
			repeat (4) @(posedge i_clk);
			o_serial_clk <= 1'b1;
			repeat (4) @(posedge i_clk);
			o_serial_clk <= 1'b0;
		end
		repeat (2) @(posedge i_clk);
		// Past its hold time the data line no longer shows the last bit.
		o_serial_input_line <= ~o_serial_input_line;
		if (rel)
			o_serial_select_n <= 1'b1;
	endtask
endmodule // cscr_host
`default_nettype wire

/* File: verif/tb_top.sv */
`default_nettype none
`define CHK(a, b) \
	total_checks++; \
	if ((a) !== (b)) begin \
		num_errors++; \
		$display("Error at %0t: got %h expected %h", $time, a, b); \
	end
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] IMP = 16'hec0e;
	logic        i_clk = 1'b0;
	logic        i_rst = 1'b1;
	logic        ext_mode = 1'b1;
	logic        sclk, sel_n, sdat, duty, phase, sdr, swing, edge_sel;
	logic [8:0]  i_ofs, q_ofs, i_fs, q_fs;
	logic [15:0] des_en, des_crs, des_fin;
	logic [15:0] mdl [16];
	logic [15:0] por [16];
	int          num_errors = 0;
	int          total_checks = 0;
	int unsigned seed_val;
	// The clock toggles every half period of 4 ns.
	always #4 i_clk = ~i_clk;
	cscr_host host (.i_clk(i_clk), .o_serial_clk(sclk),
		.o_serial_select_n(sel_n), .o_serial_input_line(sdat));
	cscr_regs dut (.i_clk(i_clk), .i_rst(i_rst), .i_serial_clk(sclk),
		.i_serial_select_n(sel_n), .i_serial_input_line(sdat),
		.i_extended_mode(ext_mode), .o_clock_duty_stabilizer(duty),
		.o_ddr_strobe_phase(phase), .o_double_rate_disable(sdr),
		.o_output_swing_select(swing), .o_output_edge_select(edge_sel),
		.o_i_offset(i_ofs), .o_q_offset(q_ofs), .o_i_fullscale(i_fs),
		.o_q_fullscale(q_fs), .o_des_enable(des_en),
		.o_des_coarse(des_crs), .o_des_fine(des_fin));
	// Compares every output with the model, power-on words in normal mode.
	task automatic check_all();
		logic [15:0] m [16];
		for (int a = 0; a < 16; a++)
			m[a] = ext_mode ? mdl[a] : por[a];
		`CHK(duty, m[1][cscr_pkg::CFG_DUTY])
		`CHK(phase, m[1][cscr_pkg::CFG_PHASE])
		`CHK(sdr, m[1][cscr_pkg::CFG_SDR])
		`CHK(swing, m[1][cscr_pkg::CFG_SWING])
		`CHK(edge_sel, m[1][cscr_pkg::CFG_EDGE])
		`CHK(i_ofs, {m[2][7], m[2][15:8]})
		`CHK(q_ofs, {m[10][7], m[10][15:8]})
		`CHK(i_fs, m[3][15:7])
		`CHK(q_fs, m[11][15:7])
		`CHK(des_en, m[13])
		`CHK(des_crs, m[14])
		`CHK(des_fin, m[15])
	endtask
	// Random data with the must-be-one bits set.
	function automatic logic [15:0] pick(input logic [3:0] a);
		logic [15:0] r;
		r = 16'($urandom);
		if (a == cscr_pkg::ADDR_CONFIG)
			return {3'b101, r[12:8], 8'hff};
		if (a == cscr_pkg::ADDR_I_FS || a == cscr_pkg::ADDR_Q_FS)
			r[15:7] = 9'h0c0 + 9'(r[15:7] % 9'h101);
		return {r[15:7], 7'h7f};
	endfunction
	// Sends one frame, updates the model and compares.
	task automatic write_reg(input logic [3:0] a, input logic [15:0] d,
		input int nbits, input bit rel);
		host.send({cscr_pkg::HEADER_CODE, a, d}, nbits, rel);
		if (nbits == 32 && IMP[a])
			mdl[a] = d;
		repeat (8) @(posedge i_clk);
		check_all();
	endtask
	// Holds reset for four cycles and expects power-on values.
	task automatic apply_reset();
		i_rst <= 1'b1;
		repeat (4) @(posedge i_clk);
		i_rst <= 1'b0;
		mdl = por;
		repeat (4) @(posedge i_clk);
		check_all();
	endtask
	task automatic tally_and_finish();
		$display("Checks %0d, errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Cuts a hung run short and counts it as a mismatch.
	initial begin
		repeat (20000) @(posedge i_clk);
		num_errors++;
		tally_and_finish();
	end
	// Main sequence of scenarios.
	initial begin
		por = '{default: 16'h0000};
		por[1] = cscr_pkg::RST_CONFIG;
		por[2] = cscr_pkg::RST_OFS;
		por[3] = cscr_pkg::RST_FS;
		por[10] = cscr_pkg::RST_OFS;
		por[11] = cscr_pkg::RST_FS;
		por[13] = cscr_pkg::RST_DES_EN;
		por[14] = cscr_pkg::RST_DES_CRS;
		por[15] = cscr_pkg::RST_DES_FIN;
		seed_val = $urandom(32'h1eafb48a);
		apply_reset();
		// Every address twice, select held low through each pass and released after address 15.
		for (int p = 0; p < 2; p++)
			for (int a = 0; a < 16; a++)
				write_reg(4'(a), pick(4'(a)), 32, a == 15);
		// A frame cut short by deselect must write nothing.
		write_reg(4'h2, pick(4'h2), 20, 1'b1);
		write_reg(4'h1, pick(4'h1), 32, 1'b1);
		// Normal mode shows power-on values, even after a write.
		ext_mode <= 1'b0;
		repeat (4) @(posedge i_clk);
		check_all();
		write_reg(4'h1, pick(4'h1), 32, 1'b1);
		ext_mode <= 1'b1;
		apply_reset();
		write_reg(4'h3, pick(4'h3), 32, 1'b1);
		tally_and_finish();
	end
endmodule // tb_top
`default_nettype wire
